// *** logic/scan_ctrl_pkg.sv ***
package scan_ctrl_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned RESUME_TIME_S = 16;
  localparam int unsigned RESUME_CYCLES = RESUME_TIME_S * CLK_HZ;
  localparam int unsigned LOCKOUT_MS    = 20;
  localparam int unsigned LOCKOUT_CYCLES = LOCKOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned TIMER_W       = 30;
  localparam int unsigned LOCK_W        = 20;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_ADDR   = 8'h00;
  localparam logic [7:0]  STATUS_ADDR = 8'h04;
  localparam logic [7:0]  TIMER_ADDR  = 8'h08;
  localparam int unsigned MODE_LSB    = 0;
  localparam int unsigned MODE_W      = 2;
  localparam logic [1:0]  MODE_RESET  = 2'h0;

  // ----------------------------------------------------------------
  // Modes and states
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_HOLD   = 2'h0;
  localparam logic [1:0] MODE_AUTO   = 2'h1;
  localparam logic [1:0] MODE_MEMORY = 2'h2;

  typedef enum logic [1:0] {
    scan_idle,
    scan_running,
    scan_manual_halt,
    scan_signal_halt
  } scan_state_t;

  // Key routing outputs travel together
  typedef struct packed {
    logic run_key_input;
    logic stop_key_first;
    logic stop_key_second;
    logic memory_write_req;
  } key_out_t;

  // Whole state of the control block
  typedef struct packed {
    logic [MODE_W-1:0]  mode;
    scan_state_t        state;
    logic [TIMER_W-1:0] timer;
    logic [LOCK_W-1:0]  lock;
    logic [2:0]         btn_sync;
    logic [2:0]         sql_sync;
    logic [1:0]         mc_sync;
    logic [1:0]         strobe_sync;
    key_out_t           keys;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
  } ctrl_state_t;

endpackage : scan_ctrl_pkg

// *** logic/scan_start_stop_control.sv ***
`timescale 1ns/1ps

// What this block does
// - Button press starts scan via run key
// - Press while scanning enters manual halt
// - Squelch edge while scanning enters signal halt
// - Hold mode: press after signal halt resumes
// - Auto mode start and halts match hold mode
// - Auto mode: signal halt restarts after 16 s
// - Auto mode: press during delay manual halts
// - Memory channel selected: reset scan, enable write
// - Mode select chooses hold, auto, memory scan
module scan_start_stop_control #(
  parameter int unsigned RESUME_CYCLES  = scan_ctrl_pkg::RESUME_CYCLES,
  parameter int unsigned LOCKOUT_CYCLES = scan_ctrl_pkg::LOCKOUT_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scan_write_button,
  input  wire logic        squelch_open_signal,
  input  wire logic        memory_channel_selected,
  input  wire logic        scan_strobe_line,
  output logic             run_key_input,
  output logic             stop_key_first,
  output logic             stop_key_second,
  output logic             memory_write_req
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam logic [scan_ctrl_pkg::TIMER_W-1:0] RESUME_LOAD =
    scan_ctrl_pkg::TIMER_W'(RESUME_CYCLES);
  localparam logic [scan_ctrl_pkg::LOCK_W-1:0] LOCK_LOAD =
    scan_ctrl_pkg::LOCK_W'(LOCKOUT_CYCLES);

  scan_ctrl_pkg::ctrl_state_t s;
  scan_ctrl_pkg::ctrl_state_t next_s;

  logic btn_pulse;
  logic sql_rise;
  logic mc_high;
  logic auto_mode;

  // Clean one-shot: lockout masks contact bounce after a press
  assign btn_pulse = s.btn_sync[1] & ~s.btn_sync[2]
                     & (s.lock == '0);
  assign sql_rise  = s.sql_sync[1] & ~s.sql_sync[2];
  assign mc_high   = s.mc_sync[1];
  assign auto_mode = (s.mode == scan_ctrl_pkg::MODE_AUTO);

  function automatic logic [31:0] read_word(
    input scan_ctrl_pkg::ctrl_state_t st,
    input logic [7:0]                 addr
  );
    read_word = 32'h0;
    case (addr)
      scan_ctrl_pkg::CTRL_ADDR:   read_word = {30'h0, st.mode};
      scan_ctrl_pkg::STATUS_ADDR: read_word = {29'h0, st.mc_sync[1],
                                               st.state};
      scan_ctrl_pkg::TIMER_ADDR:  read_word = {2'h0, st.timer};
      default:                    read_word = 32'h0;
    endcase
  endfunction : read_word

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    // Button and squelch chains have three stages, memory channel and strobe two: stage 0 feeds stage 1 only
    next_s.btn_sync    = {s.btn_sync[1:0], scan_write_button};
    next_s.sql_sync    = {s.sql_sync[1:0], squelch_open_signal};
    next_s.mc_sync     = {s.mc_sync[0], memory_channel_selected};
    next_s.strobe_sync = {s.strobe_sync[0], scan_strobe_line};
    next_s.keys.memory_write_req = 1'b0;

    if (btn_pulse) begin
      next_s.lock = LOCK_LOAD;
    end else if (s.lock != '0) begin
      next_s.lock = s.lock - 1'b1;
    end

    if (s.timer != '0) begin
      next_s.timer = s.timer - 1'b1;
    end

    if (mc_high) begin
      // Scan flip-flops held clear, button becomes a write request
      next_s.state = scan_ctrl_pkg::scan_idle;
      next_s.timer = '0;
      next_s.keys.memory_write_req = btn_pulse;
    end else begin
      case (s.state)
        scan_ctrl_pkg::scan_idle: begin
          if (btn_pulse) begin
            next_s.state = scan_ctrl_pkg::scan_running;
          end
        end
        scan_ctrl_pkg::scan_running: begin
          // Button wins when both arrive in one cycle
          if (btn_pulse) begin
            next_s.state = scan_ctrl_pkg::scan_manual_halt;
          end else if (sql_rise) begin
            next_s.state = scan_ctrl_pkg::scan_signal_halt;
            next_s.timer = auto_mode ? RESUME_LOAD : '0;
          end
        end
        scan_ctrl_pkg::scan_manual_halt: begin
          if (btn_pulse) begin
            next_s.state = scan_ctrl_pkg::scan_running;
          end
        end
        scan_ctrl_pkg::scan_signal_halt: begin
          if (btn_pulse) begin
            next_s.timer = '0;
            next_s.state = auto_mode
              ? scan_ctrl_pkg::scan_manual_halt
              : scan_ctrl_pkg::scan_running;
          end else if (auto_mode && s.timer ==
                       scan_ctrl_pkg::TIMER_W'(1)) begin
            next_s.state = scan_ctrl_pkg::scan_running;
          end
        end
        default: next_s.state = scan_ctrl_pkg::scan_idle;
      endcase
    end

    // Strobe steered to the keys chosen by the routing state
    next_s.keys.run_key_input = s.strobe_sync[1]
      & (s.state == scan_ctrl_pkg::scan_running);
    next_s.keys.stop_key_first = s.strobe_sync[1]
      & ((s.state == scan_ctrl_pkg::scan_manual_halt)
         | (s.state == scan_ctrl_pkg::scan_signal_halt));
    next_s.keys.stop_key_second = s.strobe_sync[1]
      & (s.state == scan_ctrl_pkg::scan_signal_halt);

    // APB: decode in setup so data stands through the access phase
    next_s.pready = 1'b1;
    if (psel && !penable) begin
      next_s.prdata  = read_word(s, paddr);
      next_s.pslverr = (paddr != scan_ctrl_pkg::CTRL_ADDR)
                     & (paddr != scan_ctrl_pkg::STATUS_ADDR)
                     & (paddr != scan_ctrl_pkg::TIMER_ADDR);
    end
    if (psel && penable && pwrite
        && paddr == scan_ctrl_pkg::CTRL_ADDR) begin
      next_s.mode = pwdata[scan_ctrl_pkg::MODE_LSB +: scan_ctrl_pkg::MODE_W];
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s       <= '0;
      s.mode  <= scan_ctrl_pkg::MODE_RESET;
      s.state <= scan_ctrl_pkg::scan_idle;
    end else begin
      s <= next_s;
    end
  end

  assign prdata           = s.prdata;
  assign pready           = s.pready;
  assign pslverr          = s.pslverr;
  assign run_key_input    = s.keys.run_key_input;
  assign stop_key_first   = s.keys.stop_key_first;
  assign stop_key_second  = s.keys.stop_key_second;
  assign memory_write_req = s.keys.memory_write_req;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence press_free;
    btn_pulse && !mc_high;
  endsequence

  sequence squelch_only;
    sql_rise && !btn_pulse && !mc_high;
  endsequence

  chk_idle_start: assert property (
    (s.state == scan_ctrl_pkg::scan_idle) ##0 press_free
    |=> s.state == scan_ctrl_pkg::scan_running)
    else $error("press in idle did not start scan");

  chk_run_manual: assert property (
    (s.state == scan_ctrl_pkg::scan_running) ##0 press_free
    |=> s.state == scan_ctrl_pkg::scan_manual_halt)
    else $error("press while scanning did not halt");

  chk_signal_halt: assert property (
    (s.state == scan_ctrl_pkg::scan_running) ##0 squelch_only
    |=> s.state == scan_ctrl_pkg::scan_signal_halt)
    else $error("squelch edge did not halt scan");

  chk_hold_resume: assert property (
    (s.state == scan_ctrl_pkg::scan_signal_halt && !auto_mode)
    ##0 press_free |=> s.state == scan_ctrl_pkg::scan_running)
    else $error("hold mode press did not resume");

  chk_auto_press: assert property (
    (s.state == scan_ctrl_pkg::scan_signal_halt && auto_mode)
    ##0 press_free |=> s.state == scan_ctrl_pkg::scan_manual_halt
    ##1 !run_key_input)
    else $error("auto mode press did not manual halt");

  chk_auto_restart: assert property (
    (s.state == scan_ctrl_pkg::scan_signal_halt && auto_mode
     && s.timer == scan_ctrl_pkg::TIMER_W'(1) && !btn_pulse && !mc_high)
    |=> s.state == scan_ctrl_pkg::scan_running)
    else $error("auto restart did not occur");

  chk_timer_load: assert property (
    (s.state == scan_ctrl_pkg::scan_running && auto_mode) ##0 squelch_only
    |=> s.timer == RESUME_LOAD)
    else $error("resume delay not loaded");

  chk_mc_clear: assert property (
    mc_high |=> s.state == scan_ctrl_pkg::scan_idle && s.timer == '0
    ##1 !run_key_input && !stop_key_first)
    else $error("memory channel did not clear scan");

  chk_stop_pair: assert property (
    stop_key_second |-> stop_key_first && !run_key_input)
    else $error("second stop key without first");

endmodule : scan_start_stop_control

// *** test/key_scan_model.sv ***
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Processor key matrix sweep
// ----------------------------------------------------------------
module key_scan_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run_key_input,
  input  wire logic       stop_key_first,
  input  wire logic       stop_key_second,
  input  wire logic       transmit,
  output logic            scan_strobe_line,
  output logic [2:0]      key_code,
  output logic            resume_point,
  output logic            scanning
);
  logic [2:0] phase;
  logic [2:0] seen;

  // Keys lag the strobe, so a whole sweep is gathered before latching
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase            <= 3'h0;
      seen             <= 3'h0;
      key_code         <= 3'h0;
      resume_point     <= 1'b0;
      scan_strobe_line <= 1'b0;
      scanning         <= 1'b0;
    end else begin
      phase            <= phase + 3'h1;
      scan_strobe_line <= (phase < 3'h4);
      seen <= seen | {run_key_input, stop_key_first, stop_key_second};
      if (phase == 3'h7) begin
        key_code <= seen;
        seen     <= 3'h0;
      end
      // Both stop keys mark the frequency to restart from
      resume_point <= stop_key_first & stop_key_second;
      // Transmit stops a scan whatever the key routing says
      if (transmit) begin
        scanning <= 1'b0;
      end else if (phase == 3'h7) begin
        scanning <= (seen == 3'h4);
      end
    end
  end
endmodule : key_scan_model

// *** test/scan_start_stop_control_tb_top.sv ***
`timescale 1ns/1ps

module scan_start_stop_control_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        btn, sql, mc, strobe, run_k, stop1, stop2, wr_req, err;
  logic        tx, scanning;
  logic [2:0]  key_code;
  int          fail_count, comparisons, wr_count;
  localparam bit on_btn = 1'b0;
  localparam bit on_sql = 1'b1;

  // ----------------------------------------------------------------
  // Clock, design and partner
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  scan_start_stop_control #(.RESUME_CYCLES(50), .LOCKOUT_CYCLES(4)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scan_write_button(btn),
    .squelch_open_signal(sql), .memory_channel_selected(mc),
    .scan_strobe_line(strobe), .run_key_input(run_k),
    .stop_key_first(stop1), .stop_key_second(stop2),
    .memory_write_req(wr_req));

  key_scan_model model_u (
    .pclk(pclk), .presetn(presetn), .run_key_input(run_k),
    .stop_key_first(stop1), .stop_key_second(stop2),
    .transmit(tx), .scan_strobe_line(strobe), .key_code(key_code),
    .resume_point(), .scanning(scanning));

  // Write pulses are one cycle wide, so count them as they pass
  always @(posedge pclk) if (wr_req === 1'b1) wr_count++;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Idle edge keeps the next setup off this release
    @(posedge pclk);
  endtask : apb

  task automatic pulse(input bit to_sql, input int gap);
    if (to_sql) sql <= 1'b1;
    else btn <= 1'b1;
    repeat (6) @(posedge pclk);
    if (to_sql) sql <= 1'b0;
    else btn <= 1'b0;
    repeat (gap) @(posedge pclk);
  endtask : pulse

  // State read back over the bus, routing seen by the partner
  task automatic expect_st(input logic [1:0] st, input logic [2:0] code);
    repeat (24) @(posedge pclk);
    apb(1'b0, scan_ctrl_pkg::STATUS_ADDR, 32'h0);
    chk(rd & 32'h3, {30'h0, st});
    chk({29'h0, key_code}, {29'h0, code});
  endtask : expect_st

  task automatic wrap_up();
    if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  // A full run is under 3000 cycles
  initial begin
    #(25 * 20000);
    fail_count++;
    wrap_up();
  end

  initial begin
    {presetn, psel, penable, pwrite, btn, sql, mc, tx} = 8'h0;
    paddr  = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    expect_st(2'h0, 3'h0);
    apb(1'b0, 8'h0c, 32'h0);
    chk({31'h0, err}, 32'h1);
    // Hold and memory scan share the stop-on-signal routing
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, scan_ctrl_pkg::CTRL_ADDR, 32'(i * 2));
      apb(1'b0, scan_ctrl_pkg::CTRL_ADDR, 32'h0);
      chk(rd, 32'(i * 2));
      chk({31'h0, err}, 32'h0);
      pulse(on_btn, 10);
      expect_st(2'h1, 3'h4);
      pulse(on_btn, 10);
      expect_st(2'h2, 3'h2);
      pulse(on_btn, 10);
      pulse(on_sql, 10);
      expect_st(2'h3, 3'h3);
      repeat (60) @(posedge pclk);
      expect_st(2'h3, 3'h3);
      pulse(on_btn, 10);
      expect_st(2'h1, 3'h4);
      pulse(on_btn, 10);
    end
    apb(1'b1, scan_ctrl_pkg::CTRL_ADDR, 32'h1);
    pulse(on_btn, 10);
    expect_st(2'h1, 3'h4);
    pulse(on_sql, 10);
    apb(1'b0, scan_ctrl_pkg::STATUS_ADDR, 32'h0);
    chk(rd & 32'h3, 32'h3);
    // Delay still counting, so the remainder sits below the load of 50
    apb(1'b0, scan_ctrl_pkg::TIMER_ADDR, 32'h0);
    chk({31'h0, rd > 32'h0 && rd < 32'h32}, 32'h1);
    repeat (60) @(posedge pclk);
    expect_st(2'h1, 3'h4);
    chk({31'h0, scanning}, 32'h1);
    tx <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({31'h0, scanning}, 32'h0);
    tx <= 1'b0;
    pulse(on_sql, 0);
    pulse(on_btn, 0);
    repeat (60) @(posedge pclk);
    expect_st(2'h2, 3'h2);
    mc <= 1'b1;
    expect_st(2'h0, 3'h0);
    chk(rd & 32'h4, 32'h4);
    pulse(on_btn, 10);
    chk(32'(wr_count), 32'h1);
    mc <= 1'b0;
    wrap_up();
  end
endmodule : scan_start_stop_control_tb_top
